// ==== core/sas_defs.vh ====
// Register map, field positions, reset values and state codes of the acquisition sequencer.
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH
`define SAS_OFS_CTRL        8'h00
`define SAS_OFS_STATUS      8'h04
`define SAS_OFS_START       8'h08
`define SAS_OFS_CONV_CLEAR  8'h0c
`define SAS_OFS_LIST_CLEAR  8'h10
`define SAS_OFS_LIST_ENTRY  8'h14
`define SAS_OFS_LIST_LOAD   8'h18
`define SAS_OFS_FIFO_DATA   8'h1c
`define SAS_OFS_COUNT_LO    8'h20
`define SAS_OFS_COUNT_HI    8'h24
`define SAS_CTRL_ACQ_EN     0
`define SAS_CTRL_SCAN_EN    1
`define SAS_CTRL_SCAN_DIV   2
`define SAS_CTRL_WIDE       3
`define SAS_CTRL_INT_GATE_N 4
`define SAS_CTRL_EXT_CONV   5
`define SAS_CTRL_W          6
`define SAS_CTRL_RST        6'h10
`define SAS_ST_NOT_EMPTY    0
`define SAS_ST_OVERRUN_N    1
`define SAS_ST_OVERFLOW_N   2
`define SAS_ST_RUNNING      3
`define SAS_ST_HALTED       4
`define SAS_ENTRY_W         8
`define SAS_END_FLAG_BIT    8
`define SAS_COUNT_RST       16'h0000
`define SAS_STATE_IDLE      2'h0
`define SAS_STATE_RUN       2'h1
`define SAS_STATE_HALT      2'h2
`endif

// ==== core/sas_sync.v ====
// Three-stage pin synchroniser with a debounced level and a falling-edge pulse.
`timescale 1ns/10ps
module sas_sync (
  input  wire clk,    // Board clock.
  input  wire nrst,   // Asynchronous reset, active low.
  input  wire pin,    // Asynchronous pin level.
  output reg  level_r, // Accepted level.
  output reg  fall_r   // One-cycle pulse on an accepted falling edge.
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // A change is accepted only when stages two and three agree; stage one feeds stage two only.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      level_r <= 1'b1;
      fall_r  <= 1'b0;
    end else begin
      s1_r    <= pin;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      fall_r  <= 1'b0;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
        fall_r  <= level_r & ~s3_r;
      end
    end
  end
endmodule

// ==== core/sas_fifo.v ====
// Conversion result FIFO held in flip-flops, with full and empty flags.
`timescale 1ns/10ps
module sas_fifo #(
  parameter W  = 16,  // Result width.
  parameter AW = 4    // Log2 of depth.
) (
  input  wire          clk,   // Board clock.
  input  wire          nrst,  // Asynchronous reset, active low.
  input  wire          clr,   // Synchronous empty.
  input  wire          push,  // Write one result.
  input  wire [W-1:0]  din,   // Result to write.
  input  wire          pop,   // Drop the head result.
  output wire [W-1:0]  dout,  // Head result.
  output wire          empty, // No result waiting.
  output wire          full   // No room left.
);
  reg [W-1:0] mem_r [0:(1<<AW)-1];
  reg [AW:0]  wp_r;
  reg [AW:0]  rp_r;

  assign empty = (wp_r == rp_r);
  assign full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign dout  = mem_r[rp_r[AW-1:0]];

  // Pointers carry one extra bit so full and empty are told apart.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else if (clr) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (push && !full) wp_r <= wp_r + 1'b1;
      if (pop && !empty) rp_r <= rp_r + 1'b1;
    end
  end

  // Storage needs no reset; unread words are never presented as valid.
  always @(posedge clk) begin
    if (push && !full && !clr) mem_r[wp_r[AW-1:0]] <= din;
  end
endmodule

// ==== core/sas_top.v ====
// Scanning acquisition sequencer: APB registers, scan list, sample counter, triggers, FIFO and halts.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "sas_defs.vh"
module sas_top #(
  parameter LIST_AW = 4,  // Log2 of scan-list depth.
  parameter FIFO_AW = 4,  // Log2 of FIFO depth.
  parameter DATA_W  = 16  // Converter result width.
) (
  input  wire        clk,                 // Board clock, 25 MHz.
  input  wire        nrst,                // Asynchronous reset, active low.
  input  wire        psel,                // APB select.
  input  wire        penable,             // APB access phase.
  input  wire        pwrite,              // APB direction, high for write.
  input  wire [7:0]  paddr,               // APB byte address.
  input  wire [31:0] pwdata,              // APB write data.
  output reg  [31:0] prdata,              // APB read data.
  output reg         pready,              // APB ready.
  output reg         pslverr,             // APB error on unmapped address.
  input  wire        interval_pulse_n,    // Sample-interval timer output, active low pulses.
  input  wire        timer_one_output,    // Timer output one, active low pulses.
  input  wire        external_trigger_n,  // Hardware trigger pin.
  input  wire        external_convert_n,  // External convert pin.
  input  wire        external_gate_n,     // External gate pin, low pauses conversions.
  input  wire        adc_busy,            // Converter is converting.
  input  wire        adc_done,            // One-cycle pulse, result valid.
  input  wire [DATA_W-1:0] adc_data,      // Converter result.
  output reg         conv_start_r,        // One-cycle convert command to the converter.
  output reg  [`SAS_ENTRY_W-1:0] mux_entry_r, // Channel and gain of the current entry.
  output reg         interval_gate_r,     // Enables the sample-interval timer.
  output reg         running_r            // Acquisition in progress.
);
  localparam ENTRY_FW = `SAS_ENTRY_W + 1;

  reg [`SAS_CTRL_W-1:0] ctrl_r;
  reg [15:0]            cnt_lo_r;
  reg [15:0]            cnt_hi_r;
  reg [1:0]             state_r;
  reg [1:0]             state_nxt;
  reg                   overrun_n_r;
  reg                   overflow_n_r;
  reg [LIST_AW-1:0]     list_wp_r;
  reg [LIST_AW-1:0]     list_idx_r;
  reg [ENTRY_FW-1:0]    list_r [0:(1<<LIST_AW)-1];
  reg                   rd_fifo_ok_r;

  wire trig_fall;
  wire conv_fall;
  wire int_fall;
  wire t1_fall;
  wire gate_lvl;
  wire fifo_empty;
  wire fifo_full;
  wire [DATA_W-1:0] fifo_dout;

  // Control fields.
  wire acq_en   = ctrl_r[`SAS_CTRL_ACQ_EN];
  wire scan_en  = ctrl_r[`SAS_CTRL_SCAN_EN];
  wire scan_div = ctrl_r[`SAS_CTRL_SCAN_DIV];
  wire wide     = ctrl_r[`SAS_CTRL_WIDE];
  wire int_gate = ~ctrl_r[`SAS_CTRL_INT_GATE_N];
  wire ext_conv = ctrl_r[`SAS_CTRL_EXT_CONV];

  // APB decode; effects land on the edge where the slave answers ready.
  wire acc      = psel & penable & pready;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire wr_ctrl  = wr & (paddr == `SAS_OFS_CTRL);
  wire wr_clr   = wr & (paddr == `SAS_OFS_CONV_CLEAR);
  wire wr_lclr  = wr & (paddr == `SAS_OFS_LIST_CLEAR);
  wire wr_entry = wr & (paddr == `SAS_OFS_LIST_ENTRY);
  wire wr_load  = wr & (paddr == `SAS_OFS_LIST_LOAD);
  wire wr_lo    = wr & (paddr == `SAS_OFS_COUNT_LO);
  wire wr_hi    = wr & (paddr == `SAS_OFS_COUNT_HI);
  wire rd_fifo  = rd & (paddr == `SAS_OFS_FIFO_DATA);

  // Returns high for every offset that holds a register.
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `SAS_OFS_CTRL) || (a == `SAS_OFS_STATUS) || (a == `SAS_OFS_START) ||
               (a == `SAS_OFS_CONV_CLEAR) || (a == `SAS_OFS_LIST_CLEAR) ||
               (a == `SAS_OFS_LIST_ENTRY) || (a == `SAS_OFS_LIST_LOAD) ||
               (a == `SAS_OFS_FIFO_DATA) || (a == `SAS_OFS_COUNT_LO) || (a == `SAS_OFS_COUNT_HI);
    end
  endfunction

  wire sw_start = wr & (paddr == `SAS_OFS_START) & (pwdata[15:0] == 16'h0000);
  wire trigger  = sw_start | trig_fall;

  wire conv_req = ext_conv ? conv_fall : int_fall;

  wire gated    = int_gate | ~gate_lvl;
  wire issue    = (state_r == `SAS_STATE_RUN) & conv_req & ~gated;

  // Overrun: a new conversion while the last one is still in hand.
  wire overrun_evt  = issue & (adc_busy | conv_start_r);
  wire overflow_evt = adc_done & fifo_full;

  // Current entry and whether it closes the scan.
  wire [ENTRY_FW-1:0] cur_ent = list_r[list_idx_r];
  wire cur_last = cur_ent[`SAS_END_FLAG_BIT] | ~scan_en;

  // concatenated count when wide select is set
  wire cnt_zero = (cnt_lo_r == 16'h0000) & (~wide | (cnt_hi_r == 16'h0000));
  wire cnt_last = wide ? (cnt_hi_r == 16'h0000) & (cnt_lo_r <= 16'h0001) : (cnt_lo_r <= 16'h0001);

  // stop after the final entry once the count is exhausted
  wire finish = issue & ~overrun_evt & cnt_last & cur_last;

  sas_sync u_trig (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (external_trigger_n),
    .level_r (),
    .fall_r  (trig_fall)
  );

  sas_sync u_conv (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (external_convert_n),
    .level_r (),
    .fall_r  (conv_fall)
  );

  sas_sync u_int (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (interval_pulse_n),
    .level_r (),
    .fall_r  (int_fall)
  );

  sas_sync u_t1 (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (timer_one_output),
    .level_r (),
    .fall_r  (t1_fall)
  );

  sas_sync u_gate (
    .clk     (clk),
    .nrst    (nrst),
    .pin     (external_gate_n),
    .level_r (gate_lvl),
    .fall_r  ()
  );

  // results queue until the host reads them
  sas_fifo #(
    .W  (DATA_W),
    .AW (FIFO_AW)
  ) u_fifo (
    .clk   (clk),
    .nrst  (nrst),
    .clr   (wr_clr),
    .push  (adc_done),
    .din   (adc_data),
    .pop   (rd_fifo & rd_fifo_ok_r),
    .dout  (fifo_dout),
    .empty (fifo_empty),
    .full  (fifo_full)
  );

  // Sequencer state; an error halts until the converter is cleared.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `SAS_STATE_IDLE: begin
        if (acq_en && trigger)
          state_nxt = `SAS_STATE_RUN;
      end
      `SAS_STATE_RUN: begin
        if (overrun_evt || overflow_evt)
          state_nxt = `SAS_STATE_HALT;
        else if (finish || !acq_en)
          state_nxt = `SAS_STATE_IDLE;
      end
      `SAS_STATE_HALT: begin
        if (wr_clr)
          state_nxt = `SAS_STATE_IDLE;
      end
      default: state_nxt = `SAS_STATE_IDLE;
    endcase
  end

  // State, outputs and error flags.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r         <= `SAS_STATE_IDLE;
      conv_start_r    <= 1'b0;
      interval_gate_r <= 1'b0;
      running_r       <= 1'b0;
      overrun_n_r     <= 1'b1;
      overflow_n_r    <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      conv_start_r <= issue & ~overrun_evt;
      running_r    <= (state_nxt == `SAS_STATE_RUN);
      // interval timer runs only while running
      interval_gate_r <= (state_nxt == `SAS_STATE_RUN) & ~ext_conv;
      // flag set wins over a clear in the same cycle
      if (overrun_evt && state_r == `SAS_STATE_RUN)
        overrun_n_r <= 1'b0;
      else if (wr_clr)
        overrun_n_r <= 1'b1;
      if (overflow_evt)
        overflow_n_r <= 1'b0;
      else if (wr_clr)
        overflow_n_r <= 1'b1;
    end
  end

  // Sample counter pair, written by the host and stepped by each counted conversion.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_lo_r <= `SAS_COUNT_RST;
      cnt_hi_r <= `SAS_COUNT_RST;
    end else if (state_r != `SAS_STATE_RUN) begin
      if (wr_lo)
        cnt_lo_r <= pwdata[15:0];
      if (wr_hi)
        cnt_hi_r <= pwdata[15:0];
    end else if (issue && !overrun_evt && !cnt_zero) begin
      // low counts conversions, high steps as low goes from one to zero
      cnt_lo_r <= cnt_lo_r - 16'h0001;
      if (wide && cnt_lo_r == 16'h0001)
        cnt_hi_r <= cnt_hi_r - 16'h0001;
    end
  end

  // Scan-list writes; the write pointer restarts on a list clear.
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      list_wp_r <= {LIST_AW{1'b0}};
    else if (wr_lclr)
      list_wp_r <= {LIST_AW{1'b0}};
    else if (wr_entry)
      list_wp_r <= list_wp_r + 1'b1;
  end

  // Entries live in plain flip-flops without reset to keep the list cheap.
  always @(posedge clk) begin
    if (wr_entry && !wr_lclr)
      list_r[list_wp_r] <= pwdata[ENTRY_FW-1:0];
  end

  // Scan index: advances per conversion, or per timer-one pulse in divided mode.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      list_idx_r  <= {LIST_AW{1'b0}};
      mux_entry_r <= {`SAS_ENTRY_W{1'b0}};
    end else begin
      mux_entry_r <= cur_ent[`SAS_ENTRY_W-1:0];
      if (wr_load)
        list_idx_r <= {LIST_AW{1'b0}};
      else if (scan_en && (scan_div ? (t1_fall && state_r == `SAS_STATE_RUN) : (issue && !overrun_evt))) begin
        if (cur_ent[`SAS_END_FLAG_BIT])
          list_idx_r <= {LIST_AW{1'b0}};
        else
          list_idx_r <= list_idx_r + 1'b1;
      end
    end
  end

  // Control register write.
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      ctrl_r <= `SAS_CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= pwdata[`SAS_CTRL_W-1:0];
  end

  // APB answer one cycle after the access phase opens; read data is captured with it.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h00000000;
      rd_fifo_ok_r <= 1'b0;
    end else begin
      pready       <= psel & penable & ~pready;
      pslverr      <= psel & penable & ~pready & ~mapped(paddr);
      rd_fifo_ok_r <= ~fifo_empty;
      prdata       <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `SAS_OFS_CTRL:      prdata <= {{(32-`SAS_CTRL_W){1'b0}}, ctrl_r};
          // status shows waiting results and errors
          `SAS_OFS_STATUS:    prdata <= {27'h0000000, (state_r == `SAS_STATE_HALT), running_r,
                                         overflow_n_r, overrun_n_r, ~fifo_empty};
          `SAS_OFS_FIFO_DATA: prdata <= {{(32-DATA_W){1'b0}}, fifo_empty ? {DATA_W{1'b0}} : fifo_dout};
          `SAS_OFS_COUNT_LO:  prdata <= {16'h0000, cnt_lo_r};
          `SAS_OFS_COUNT_HI:  prdata <= {16'h0000, cnt_hi_r};
          default:            prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ==== dv/sas_top_chk.sv ====
// Port-level assertions for the scanning acquisition sequencer.
`timescale 1ns/10ps
`include "sas_defs.vh"
module sas_top_chk (
  input wire        clk,                // Board clock.
  input wire        nrst,               // Reset, active low.
  input wire        psel,               // APB select.
  input wire        penable,            // APB access phase.
  input wire        pwrite,             // APB direction.
  input wire [7:0]  paddr,              // APB address.
  input wire [31:0] pwdata,             // APB write data.
  input wire [31:0] prdata,             // APB read data.
  input wire        pready,             // APB ready.
  input wire        pslverr,            // APB error.
  input wire        external_trigger_n, // Trigger pin.
  input wire        conv_start_r,       // Convert command.
  input wire        interval_gate_r,    // Interval timer enable.
  input wire        running_r           // Acquisition active.
);
  reg [3:0] trig_age_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Cycles since the last start write or trigger fall; a start with no cause behind it shows a large age.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trig_age_r <= 4'hf;
    end else if ((psel && penable && pready && pwrite && paddr == `SAS_OFS_START && pwdata[15:0] == 16'h0)
                 || $fell(external_trigger_n)) begin
      trig_age_r <= 4'h0;
    end else if (trig_age_r != 4'hf) begin
      trig_age_r <= trig_age_r + 4'h1;
    end
  end

  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready; endsequence

  property p_ready_wait; s_setup ##1 s_wait |=> pready; endproperty
  property p_ready_one; pready |=> !pready; endproperty
  property p_slverr_ready; pslverr |-> pready; endproperty
  property p_prdata_idle; !pready |-> prdata == 32'h0; endproperty
  property p_err_read; pready && pslverr |-> prdata == 32'h0; endproperty
  property p_conv_pulse; conv_start_r |=> !conv_start_r; endproperty
  property p_conv_running; conv_start_r |-> running_r || $past(running_r); endproperty
  property p_gate_running; $rose(interval_gate_r) |-> trig_age_r < 4'hc; endproperty
  property p_start_cause; $rose(running_r) |-> trig_age_r < 4'hc; endproperty

  a_ready_wait: assert property (p_ready_wait) else $error("pready missing after one wait");
  a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
  a_slverr_ready: assert property (p_slverr_ready) else $error("pslverr without pready");
  a_prdata_idle: assert property (p_prdata_idle) else $error("prdata not zero when idle");
  a_err_read: assert property (p_err_read) else $error("unmapped read not zero");
  a_conv_pulse: assert property (p_conv_pulse) else $error("convert command too long");
  a_conv_running: assert property (p_conv_running) else $error("convert while idle");
  a_gate_running: assert property (p_gate_running) else $error("interval gate without trigger");
  a_start_cause: assert property (p_start_cause) else $error("start without trigger");
endmodule

bind sas_top sas_top_chk u_chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .external_trigger_n, .conv_start_r, .interval_gate_r, .running_r);

// ==== dv/sas_partner.sv ====
// Converter and sample-interval timer model at the far side of the sequencer.
`timescale 1ns/10ps
module sas_partner (
  input  wire        clk,              // Board clock.
  input  wire        nrst,             // Reset, active low.
  input  wire        slow,             // Conversions outlast the interval.
  input  wire        conv_start_r,     // Convert command.
  input  wire        interval_gate_r,  // Interval timer enable.
  output reg         adc_busy,         // Converter busy.
  output reg         adc_done,         // Result valid pulse.
  output reg  [15:0] adc_data,         // Result, scrambled when not valid.
  output reg         interval_pulse_n  // Interval pulse, active low.
);
  int        bcnt;
  int        icnt;
  reg [15:0] val_r;

  // interval of twenty
  // The low part spans 4 cycles so the pin filter accepts it; the pin rests high while gated off.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      icnt <= 0;
      interval_pulse_n <= 1'b1;
    end else begin
      icnt <= interval_gate_r ? (icnt + 1) % 20 : 0;
      interval_pulse_n <= !(interval_gate_r && icnt >= 16);
    end
  end

  // A slow conversion lets the next request arrive while busy, which is how overruns are provoked.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bcnt <= 0;
      adc_busy <= 1'b0;
      adc_done <= 1'b0;
      adc_data <= 16'h0;
      val_r <= 16'h0;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (conv_start_r && !adc_busy) begin
        adc_busy <= 1'b1;
        bcnt <= slow ? 40 : 3;
      end else if (adc_busy && bcnt > 1) begin
        bcnt <= bcnt - 1;
      end else if (adc_busy) begin
        adc_busy <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= val_r;
        val_r <= val_r + 16'h1;
      end
    end
  end
endmodule

// ==== dv/sas_bench.sv ====
// Self-checking bench for the scanning acquisition sequencer.
`timescale 1ns/10ps
`include "sas_defs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module scanning_acquisition_sequencer_bench;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, slow, mon_on, rerr, div;
  logic        interval_pulse_n, timer_one_output, external_trigger_n, external_convert_n, external_gate_n;
  logic        adc_busy, adc_done, conv_start_r, interval_gate_r, running_r;
  logic [7:0]  paddr, mux_entry_r;
  logic [15:0] adc_data;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0]  lst [3];
  logic [15:0] q [$];
  int          error_cnt, checked, conv_n, mi;

  sas_top u_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .interval_pulse_n, .timer_one_output, .external_trigger_n, .external_convert_n, .external_gate_n,
    .adc_busy, .adc_done, .adc_data, .conv_start_r, .mux_entry_r, .interval_gate_r, .running_r);
  sas_partner u_far (.clk, .nrst, .slow, .conv_start_r, .interval_gate_r, .adc_busy, .adc_done, .adc_data,
    .interval_pulse_n);

  // Board clock, 40 ns period.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Model: each result joins the queue, each convert command must carry the next list entry.
  // In divided mode the entry steps on a timer-one fall instead of on each command.
  always @(posedge clk) begin
    if (adc_done) q.push_back(adc_data);
    if (conv_start_r && mon_on) begin
      `CHK(mux_entry_r, lst[mi])
      if (!div) mi = (mi + 1) % 3;
    end
    if (div && $fell(timer_one_output)) mi = (mi + 1) % 3;
    if (conv_start_r) conv_n++;
  end

  task tally_and_finish;
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input bit w, input [7:0] a, input [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  task automatic wrun(input logic v);
    int n;
    n = 0;
    while (running_r !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // Low pulse of six cycles on the trigger pin (k=0), the external convert pin (k=1) or timer output one (k=2).
  task automatic pin(input int k);
    @(posedge clk);
    if (k == 1) external_convert_n <= 1'b0;
    else if (k == 2) timer_one_output <= 1'b0;
    else external_trigger_n <= 1'b0;
    repeat (6) @(posedge clk);
    if (k == 1) external_convert_n <= 1'b1;
    else if (k == 2) timer_one_output <= 1'b1;
    else external_trigger_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // One acquisition of n samples over the three-entry list, then service of the FIFO.
  task automatic run(input int n, input bit wide, input bit hw, input bit xc, input bit ovr, input bit dv);
    int          k;
    logic [15:0] e;
    conv_n = 0;
    mi = 0;
    div = dv;
    q.delete();
    slow <= ovr;
    if (wide) begin
      apb(1, `SAS_OFS_COUNT_LO, (n[15:0] == 16'h0) ? 32'hffff : n - 1);
      apb(1, `SAS_OFS_COUNT_HI, (n[15:0] <= 16'h1) ? n >> 16 : (n >> 16) + 1);
    end else apb(1, `SAS_OFS_COUNT_LO, n);
    apb(1, `SAS_OFS_CONV_CLEAR, 0);
    apb(1, `SAS_OFS_LIST_LOAD, 0);
    apb(1, `SAS_OFS_CTRL, {26'h0, xc, 1'b1, wide, dv, 2'b11});
    if (xc) begin
      pin(1);
      `CHK(conv_n, 0)
    end
    if (hw) pin(0);
    else apb(1, `SAS_OFS_START, 0);
    wrun(1);
    @(posedge clk);
    `CHK(interval_gate_r, !xc)
    // two conversions per timer step when divided
    if (xc) repeat (n + 3) begin
      pin(1);
      if (dv) begin
        pin(1);
        pin(2);
      end
    end
    wrun(0);
    repeat (50) @(posedge clk);
    if (ovr) begin
      apb(0, `SAS_OFS_STATUS, 0);
      `CHK(rdat[4:1], 4'b1010)
      apb(1, `SAS_OFS_CONV_CLEAR, 0);
      q.delete();
    end else `CHK(conv_n, n)
    k = 0;
    apb(0, `SAS_OFS_STATUS, 0);
    while (rdat[0] === 1'b1 && k < 20) begin
      e = q.pop_front();
      apb(0, `SAS_OFS_FIFO_DATA, 0);
      `CHK(rdat[15:0], e)
      apb(0, `SAS_OFS_STATUS, 0);
      k++;
    end
    `CHK(rdat[4:0], 5'b00110)
    `CHK(q.size(), 0)
  endtask

  // Main sequence: register checks, a refused start, then normal, wide, external-convert, divided and overrun runs.
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer_one_output = 1'b1;
    external_trigger_n = 1'b1;
    external_convert_n = 1'b1;
    external_gate_n = 1'b1;
    slow = 1'b0;
    mon_on = 1'b0;
    error_cnt = 0;
    checked = 0;
    void'($urandom(32'hae216d22));
    foreach (lst[i]) lst[i] = $urandom;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(0, `SAS_OFS_CTRL, 0);
    `CHK(rdat, 32'h10)
    apb(0, 8'h40, 0);
    `CHK({rerr, rdat}, 33'h100000000)
    apb(1, `SAS_OFS_CTRL, 32'h13);
    apb(1, `SAS_OFS_START, 32'h1);
    repeat (8) @(posedge clk);
    `CHK(running_r, 1'b0)
    apb(1, `SAS_OFS_LIST_CLEAR, 0);
    for (int i = 0; i < 3; i++) apb(1, `SAS_OFS_LIST_ENTRY, {23'h0, i == 2, lst[i]});
    mon_on = 1'b1;
    run(6, 0, 0, 0, 0, 0);
    run(6, 1, 1, 0, 0, 0);
    run(3, 0, 0, 1, 0, 0);
    run(6, 0, 0, 1, 0, 1);
    mon_on = 1'b0;
    run(9, 0, 0, 0, 1, 0);
    tally_and_finish();
  end
endmodule
